/* rtl/ncr_pkg.sv */
// constants shared by the command register device end and its host end
package ncr_pkg;

	// command register bit positions
	localparam int BIT_FILTER_LOAD    = 9;
	localparam int BIT_RESOURCE_FETCH = 8;
	localparam int BIT_SOFT_RESET     = 7;
	localparam int BIT_TIMER_GO       = 5;
	localparam int BIT_TIMER_HALT     = 4;
	localparam int BIT_RECEIVE_ON     = 3;
	localparam int BIT_RECEIVE_OFF    = 2;
	localparam int BIT_TRANSMIT_CMD   = 1;
	localparam int BIT_HALT           = 0;

	localparam int CMD_W = 16;

	// register port offset of the command register on the device side
	localparam logic [5:0] DEV_CMD_OFS = 6'h00;

	// hardware reset value: soft reset, timer halt and receive off set
	localparam logic [CMD_W-1:0] CMD_HW_RESET   = 16'h0094;
	// soft reset sets these bits
	localparam logic [CMD_W-1:0] CMD_SW_SET     = 16'h0084;
	// soft reset clears these bits
	localparam logic [CMD_W-1:0] CMD_SW_CLEAR   = 16'h0303;
	// implemented bits; the rest read as zero
	localparam logic [CMD_W-1:0] CMD_VALID_MASK = 16'h03bf;
	localparam logic [CMD_W-1:0] CMD_NONE       = 16'h0000;

	localparam int TIMER_W    = 32;
	localparam int TX_ABORT_W = 4;

	// host wishbone register map (byte addresses)
	localparam logic [7:0] HOST_CMD_OFS    = 8'h00;
	localparam logic [7:0] HOST_REFUSE_OFS = 8'h04;

	// refused-command sticky flags in the host status register
	localparam int REF_FILTER_LOAD    = 0;
	localparam int REF_TRANSMIT_CMD   = 1;
	localparam int REF_RESOURCE_FETCH = 2;
	localparam int REF_W              = 3;
	localparam logic [REF_W-1:0] REFUSE_RESET = 3'h0;

	typedef enum logic [2:0]
	{
		NCR_H_IDLE   = 3'b001,
		NCR_H_SECOND = 3'b010,
		NCR_H_DONE   = 3'b100
	} ncr_host_state_t;

endpackage

/* rtl/ncr_if.sv */
// register port between the host end and the command register device
`timescale 1ns/1ps
`default_nettype none
interface ncr_if;
	import ncr_pkg::*;

	logic             wr;
	logic [CMD_W-1:0] wdata;
	logic [CMD_W-1:0] rdata;

	modport dev
	(
		input  wr,
		input  wdata,
		output rdata
	);

	modport host
	(
		output wr,
		output wdata,
		input  rdata
	);
endinterface
`default_nettype wire

/* rtl/ncr_device.sv */
// command register of the network controller, device end
`timescale 1ns/1ps
`default_nettype none
module ncr_device
(
	input  wire logic                             sys_clk_i,
	input  wire logic                             rst_i,
	ncr_if.dev                                    bus,
	input  wire logic                             filter_done_i,
	input  wire logic                             fetch_done_i,
	input  wire logic                             tx_list_end_i,
	input  wire logic                             tx_frame_done_i,
	input  wire logic [ncr_pkg::TX_ABORT_W-1:0]   tx_abort_i,
	input  wire logic                             rx_frame_busy_i,
	input  wire logic                             timer_load_i,
	input  wire logic [ncr_pkg::TIMER_W-1:0]      timer_value_i,
	input  wire logic                             timer_irq_en_i,
	output logic                                  filter_load_o,
	output logic                                  resource_fetch_o,
	output logic                                  tx_run_o,
	output logic                                  tx_halt_o,
	output logic                                  rx_buffer_en_o,
	output logic                                  sm_hold_o,
	output logic                                  crc_en_o,
	output logic                                  tally_en_o,
	output logic [ncr_pkg::TIMER_W-1:0]           timer_count_o,
	output logic                                  timer_irq_o
);
	import ncr_pkg::*;

	logic               filter_load_cmd;
	logic               resource_fetch_cmd;
	logic               soft_reset;
	logic               timer_go_bit;
	logic               timer_halt_bit;
	logic               receive_on_bit;
	logic               receive_off_bit;
	logic               transmit_command_bit;
	logic               halt_bit;
	logic               rx_turn_on;
	logic               sw_rst;
	logic               cmd_ok;
	logic               tx_done;
	logic               timer_run;
	logic               timer_expire;
	logic [TIMER_W-1:0] timer_count;

	// a write bit counts only when it is a one and reset is clear
	function automatic logic cmd_set
	(
		input logic             ok,
		input logic [CMD_W-1:0] d,
		input int               pos
	);
		cmd_set = ok & d[pos];
	endfunction

	assign sw_rst = bus.wr & bus.wdata[BIT_SOFT_RESET];
	// commands written together with or while reset is set are dropped
	assign cmd_ok = bus.wr & ~soft_reset & ~bus.wdata[BIT_SOFT_RESET];

	// soft reset bit is the only plain read/write bit
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			soft_reset <= CMD_HW_RESET[BIT_SOFT_RESET];
		else if (bus.wr)
			soft_reset <= bus.wdata[BIT_SOFT_RESET];
	end

	// filter table load; set wins over the done pulse
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			filter_load_cmd <= CMD_HW_RESET[BIT_FILTER_LOAD];
		else if (sw_rst)
			filter_load_cmd <= 1'b0;
		else if (cmd_set(cmd_ok, bus.wdata, BIT_FILTER_LOAD))
			filter_load_cmd <= 1'b1;
		else if (filter_done_i)
			filter_load_cmd <= 1'b0;
	end

	// receive resource descriptor fetch
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			resource_fetch_cmd <= CMD_HW_RESET[BIT_RESOURCE_FETCH];
		else if (sw_rst)
			resource_fetch_cmd <= 1'b0;
		else if (cmd_set(cmd_ok, bus.wdata, BIT_RESOURCE_FETCH))
			resource_fetch_cmd <= 1'b1;
		else if (fetch_done_i)
			resource_fetch_cmd <= 1'b0;
	end

	// any abort flag, end of list, or a halt taking effect ends transmission
	assign tx_done = tx_list_end_i | (|tx_abort_i) | (halt_bit & tx_frame_done_i);

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			transmit_command_bit <= CMD_HW_RESET[BIT_TRANSMIT_CMD];
		else if (sw_rst)
			transmit_command_bit <= 1'b0;
		else if (cmd_set(cmd_ok, bus.wdata, BIT_TRANSMIT_CMD))
			transmit_command_bit <= 1'b1;
		else if (tx_done)
			transmit_command_bit <= 1'b0;
	end

	// halt is sampled after each frame and drops with the transmit command
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			halt_bit <= CMD_HW_RESET[BIT_HALT];
		else if (sw_rst)
			halt_bit <= 1'b0;
		else if (cmd_set(cmd_ok, bus.wdata, BIT_HALT))
			halt_bit <= 1'b1;
		else if (tx_done | ~transmit_command_bit)
			halt_bit <= 1'b0;
	end

	// timer control; soft reset leaves both bits alone
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			timer_go_bit   <= CMD_HW_RESET[BIT_TIMER_GO];
			timer_halt_bit <= CMD_HW_RESET[BIT_TIMER_HALT];
		end
		else if (cmd_set(cmd_ok, bus.wdata, BIT_TIMER_HALT))
		begin
			// halt wins when both are written at once
			timer_go_bit   <= 1'b0;
			timer_halt_bit <= 1'b1;
		end
		else if (cmd_set(cmd_ok, bus.wdata, BIT_TIMER_GO))
		begin
			timer_go_bit   <= 1'b1;
			timer_halt_bit <= 1'b0;
		end
		else if (timer_expire)
		begin
			timer_go_bit   <= 1'b0;
			timer_halt_bit <= 1'b1;
		end
	end

	// the count freezes under soft reset like the other machines
	assign timer_run    = timer_go_bit & ~soft_reset;
	assign timer_expire = timer_run & (timer_count <= {{(TIMER_W-1){1'b0}}, 1'b1});

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			timer_count <= '0;
		else if (timer_load_i)
			timer_count <= timer_value_i;
		else if (timer_run & (timer_count != '0))
			timer_count <= timer_count - {{(TIMER_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			timer_irq_o <= 1'b0;
		else
			timer_irq_o <= timer_expire & timer_irq_en_i;
	end

	// receive on/off: changes of direction wait for an idle network,
	// so buffering starts or stops inside a frame only with soft reset or when a command reverses one still pending
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			receive_on_bit  <= CMD_HW_RESET[BIT_RECEIVE_ON];
			receive_off_bit <= CMD_HW_RESET[BIT_RECEIVE_OFF];
			rx_turn_on      <= 1'b0;
		end
		else if (sw_rst | cmd_set(cmd_ok, bus.wdata, BIT_RECEIVE_OFF))
		begin
			receive_off_bit <= 1'b1;
			rx_turn_on      <= 1'b0;
			if (!rx_frame_busy_i)
				receive_on_bit <= 1'b0;
		end
		else if (cmd_set(cmd_ok, bus.wdata, BIT_RECEIVE_ON))
		begin
			receive_on_bit <= 1'b1;
			if (rx_frame_busy_i & receive_off_bit)
				rx_turn_on <= 1'b1;
			else
				receive_off_bit <= 1'b0;
		end
		else if (!rx_frame_busy_i & receive_on_bit & receive_off_bit)
		begin
			rx_turn_on <= 1'b0;
			if (rx_turn_on)
				receive_off_bit <= 1'b0;
			else
				receive_on_bit <= 1'b0;
		end
	end

	// registered control levels toward the rest of the controller
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			filter_load_o    <= 1'b0;
			resource_fetch_o <= 1'b0;
			tx_run_o         <= 1'b0;
			tx_halt_o        <= 1'b0;
			rx_buffer_en_o   <= 1'b0;
			sm_hold_o        <= 1'b1;
			crc_en_o         <= 1'b0;
			tally_en_o       <= 1'b0;
		end
		else
		begin
			filter_load_o    <= filter_load_cmd & ~soft_reset;
			resource_fetch_o <= resource_fetch_cmd & ~soft_reset;
			tx_run_o         <= transmit_command_bit & ~soft_reset;
			tx_halt_o        <= halt_bit;
			// a frame already underway keeps buffering after receive off
			rx_buffer_en_o   <= receive_on_bit & ~soft_reset
				& (~receive_off_bit | (~rx_turn_on & rx_frame_busy_i));
			sm_hold_o        <= soft_reset;
			crc_en_o         <= ~soft_reset;
			// tallies halt without clearing and ignore receive off
			tally_en_o       <= ~soft_reset;
		end
	end

	assign timer_count_o = timer_count;

	// reserved bits 15..10 and 6 always read zero
	assign bus.rdata = {6'h00, filter_load_cmd, resource_fetch_cmd, soft_reset, 1'b0,
		timer_go_bit, timer_halt_bit, receive_on_bit, receive_off_bit,
		transmit_command_bit, halt_bit} & CMD_VALID_MASK;

endmodule
`default_nettype wire

/* rtl/ncr_host.sv */
// host end: wishbone slave that issues command register writes
`timescale 1ns/1ps
`default_nettype none
module ncr_host
(
	input  wire logic                sys_clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	ncr_if.host                      bus
);
	import ncr_pkg::*;

	ncr_host_state_t    state;
	logic               req;
	logic [CMD_W-1:0]   cur;
	logic [CMD_W-1:0]   want;
	logic [CMD_W-1:0]   safe;
	logic [REF_W-1:0]   refuse;
	logic [REF_W-1:0]   next_refuse_set;
	logic               need_split;
	logic               cmd_wr;

	assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign cur    = bus.rdata;
	// both low byte lanes are needed: a partial write could drop reset
	assign cmd_wr = req & wb_we_i & (wb_adr_i == HOST_CMD_OFS) & (&wb_sel_i[1:0])
		& (state == NCR_H_IDLE);
	assign want   = wb_dat_i[CMD_W-1:0] & CMD_VALID_MASK;

	// drop commands that would lock up the device or disturb reception
	always_comb
	begin
		safe            = want;
		next_refuse_set = REFUSE_RESET;
		if (want[BIT_FILTER_LOAD] & (cur[BIT_TRANSMIT_CMD] | want[BIT_TRANSMIT_CMD]))
		begin
			safe[BIT_FILTER_LOAD]           = 1'b0;
			next_refuse_set[REF_FILTER_LOAD] = 1'b1;
		end
		if (want[BIT_TRANSMIT_CMD] & cur[BIT_FILTER_LOAD])
		begin
			safe[BIT_TRANSMIT_CMD]           = 1'b0;
			next_refuse_set[REF_TRANSMIT_CMD] = 1'b1;
		end
		if (want[BIT_RESOURCE_FETCH] & cur[BIT_RECEIVE_ON])
		begin
			safe[BIT_RESOURCE_FETCH]            = 1'b0;
			next_refuse_set[REF_RESOURCE_FETCH] = 1'b1;
		end
	end

	// a command while reset is set needs a separate clearing write first
	assign need_split = cur[BIT_SOFT_RESET] & ~safe[BIT_SOFT_RESET]
		& (|(safe & ~CMD_SW_SET));

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state     <= NCR_H_IDLE;
			bus.wr    <= 1'b0;
			bus.wdata <= CMD_NONE;
			wb_ack_o  <= 1'b0;
		end
		else
		begin
			bus.wr   <= 1'b0;
			wb_ack_o <= 1'b0;
			case (state)
				NCR_H_IDLE:
				begin
					if (cmd_wr)
					begin
						bus.wr    <= 1'b1;
						bus.wdata <= need_split ? CMD_NONE : safe;
						state     <= need_split ? NCR_H_SECOND : NCR_H_DONE;
					end
					else if (req)
						state <= NCR_H_DONE;
				end
				NCR_H_SECOND:
				begin
					bus.wr    <= 1'b1;
					bus.wdata <= safe;
					state     <= NCR_H_DONE;
				end
				NCR_H_DONE:
				begin
					wb_ack_o <= 1'b1;
					state    <= NCR_H_IDLE;
				end
				default:
					state <= NCR_H_IDLE;
			endcase
		end
	end

	// sticky refusal flags, write one to clear, a new refusal wins
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			refuse <= REFUSE_RESET;
		else if (cmd_wr)
			refuse <= refuse | next_refuse_set;
		else if (req & wb_we_i & (wb_adr_i == HOST_REFUSE_OFS) & wb_sel_i[0]
			& (state == NCR_H_IDLE))
			refuse <= refuse & ~wb_dat_i[REF_W-1:0];
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h00000000;
		else if (state == NCR_H_DONE)
		begin
			if (wb_adr_i == HOST_CMD_OFS)
				wb_dat_o <= {16'h0000, cur};
			else if (wb_adr_i == HOST_REFUSE_OFS)
				wb_dat_o <= {{(32-REF_W){1'b0}}, refuse};
			else
				wb_dat_o <= 32'h00000000;
		end
	end

endmodule
`default_nettype wire

/* verification/ncr_checker.sv */
// concurrent checks on the register port between host end and device end
`timescale 1ns/1ps
`default_nettype none
module ncr_checker
(
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       wr,
	input  wire logic [ncr_pkg::CMD_W-1:0]  wdata,
	input  wire logic [ncr_pkg::CMD_W-1:0]  rdata
);
	import ncr_pkg::*;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	// a plain command write: reset bit clear and not being set by this write
	wire cmd_ok = wr && !rdata[7] && !wdata[7];

	reserved_bits_zero_a: assert property ((rdata & ~CMD_VALID_MASK) == CMD_NONE)
		else $error("reserved command bits read nonzero");
	hw_reset_value_a: assert property ($fell(rst_i) |-> rdata == CMD_HW_RESET)
		else $error("command word wrong after hardware reset");
	soft_reset_load_a: assert property
		(wr && wdata[7] |=> rdata[7] && rdata[2] && (rdata & CMD_SW_CLEAR) == CMD_NONE)
		else $error("soft reset left wrong bits");
	reset_blocks_cmds_a: assert property (rdata[7] |-> (rdata & CMD_SW_CLEAR) == CMD_NONE)
		else $error("command bit set while in soft reset");
	reset_clear_resume_a: assert property (wr && rdata[7] && !wdata[7] |=> !rdata[7])
		else $error("soft reset bit did not clear");
	// only bits that nothing but a write can raise; timer halt rises on expiry
	zero_write_inert_a: assert property
		(wr && wdata == CMD_NONE |=> (rdata & ~$past(rdata) & 16'h03af) == CMD_NONE)
		else $error("zero write raised a command bit");
	cmd_bits_take_a: assert property
		(cmd_ok |=> (rdata & $past(wdata) & 16'h0302) == ($past(wdata) & 16'h0302))
		else $error("written command bit not taken");
	timer_go_run_a: assert property
		(cmd_ok && wdata[5] && !wdata[4] |=> rdata[5] && !rdata[4])
		else $error("timer go did not start timer");
	timer_halt_wins_a: assert property (cmd_ok && wdata[4] |=> !rdata[5] && rdata[4])
		else $error("timer halt did not stop timer");
	rx_on_take_a: assert property (cmd_ok && wdata[3] && !wdata[2] |=> rdata[3])
		else $error("receive on bit not taken");
	rx_off_take_a: assert property (cmd_ok && wdata[2] |=> rdata[2])
		else $error("receive off bit not taken");

	cover property (wr && wdata[7]);
	cover property (wr && rdata[7] && !wdata[7]);
	cover property (cmd_ok && wdata[1]);
	cover property (cmd_ok && wdata[5]);
endmodule
`default_nettype wire

/* verification/net_ctrl_command_register_tb_top.sv */
// bench: wishbone tasks drive the host end, which commands the device end
`timescale 1ns/1ps
`default_nettype none
module net_ctrl_command_register_tb_top;
	import ncr_pkg::*;

	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic [31:0] cnt;
	logic [31:0] c;
	logic        ack;
	logic [8:0]  ev = 9'h000;
	logic        rx_busy = 1'b0;
	logic        irq_en = 1'b1;
	logic        filt_o, fetch_o, tx_run, tx_halt, rx_buf, hold, crc_en, tally_en, irq;
	int          bad_count = 0;
	int          num_checks = 0;

	always #2.5 sys_clk = ~sys_clk;

	ncr_if i_ncr_if ();

	ncr_host i_ncr_host (.sys_clk_i(sys_clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .bus(i_ncr_if.host));

	// ev bits: filter done, fetch done, list end, frame done, four aborts, timer load
	ncr_device i_ncr_device (.sys_clk_i(sys_clk), .rst_i(rst), .bus(i_ncr_if.dev),
		.filter_done_i(ev[0]), .fetch_done_i(ev[1]), .tx_list_end_i(ev[2]),
		.tx_frame_done_i(ev[3]), .tx_abort_i(ev[7:4]), .rx_frame_busy_i(rx_busy),
		.timer_load_i(ev[8]), .timer_value_i(32'd30), .timer_irq_en_i(irq_en),
		.filter_load_o(filt_o), .resource_fetch_o(fetch_o), .tx_run_o(tx_run),
		.tx_halt_o(tx_halt), .rx_buffer_en_o(rx_buf), .sm_hold_o(hold), .crc_en_o(crc_en),
		.tally_en_o(tally_en), .timer_count_o(cnt), .timer_irq_o(irq));

	ncr_checker i_ncr_checker (.sys_clk_i(sys_clk), .rst_i(rst), .wr(i_ncr_if.wr),
		.wdata(i_ncr_if.wdata), .rdata(i_ncr_if.rdata));

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// one classic cycle; request held until ack is sampled, then idle one cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			bad_count++;
			$display("ERROR %0t: no ack", $time);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic wb_rd(input logic [7:0] a, input logic [31:0] want);
		xfer(1'b0, a, 32'h0);
		check(q, want);
	endtask

	task automatic pulse(input logic [8:0] m);
		ev <= m;
		@(posedge sys_clk);
		ev <= 9'h000;
		@(posedge sys_clk);
	endtask

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		$display("ERROR %0t: watchdog expired", $time);
		give_verdict();
	end

	initial
	begin
		int n;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		wb_rd(8'h00, 32'h94);
		check({29'h0, hold, crc_en, tally_en}, 32'h4);
		// reset bit is set, so the host splits this into two device writes
		wb_wr(8'h00, 32'h2);
		wb_rd(8'h00, 32'h16);
		check({28'h0, hold, crc_en, tally_en, tx_run}, 32'h7);
		wb_wr(8'h00, 32'h0);
		wb_rd(8'h00, 32'h16);
		wb_wr(8'h00, 32'h1);
		check({31'h0, tx_halt}, 32'h1);
		pulse(9'h008);
		wb_rd(8'h00, 32'h14);
		for (int k = 0; k < 5; k++)
		begin
			wb_wr(8'h00, 32'h2);
			wb_rd(8'h00, 32'h16);
			pulse((k < 4) ? (9'h010 << k) : 9'h004);
			wb_rd(8'h00, 32'h14);
		end
		wb_wr(8'h00, 32'h200);
		check({31'h0, filt_o}, 32'h1);
		wb_wr(8'h00, 32'h2);
		wb_rd(8'h04, 32'h2);
		wb_rd(8'h00, 32'h214);
		pulse(9'h001);
		wb_rd(8'h00, 32'h14);
		wb_wr(8'h00, 32'h2);
		wb_wr(8'h00, 32'h200);
		wb_rd(8'h04, 32'h3);
		wb_rd(8'h00, 32'h16);
		pulse(9'h004);
		wb_wr(8'h04, 32'h7);
		wb_rd(8'h04, 32'h0);
		wb_wr(8'h00, 32'h100);
		wb_rd(8'h00, 32'h114);
		check({31'h0, fetch_o}, 32'h1);
		pulse(9'h002);
		wb_rd(8'h00, 32'h14);
		wb_wr(8'h00, 32'hfc40);
		wb_wr(8'h08, 32'hffff);
		wb_rd(8'h08, 32'h0);
		wb_rd(8'h00, 32'h14);
		// receive on in mid-frame must wait for the network to go idle
		rx_busy <= 1'b1;
		wb_wr(8'h00, 32'h8);
		wb_rd(8'h00, 32'h1c);
		check({31'h0, rx_buf}, 32'h0);
		rx_busy <= 1'b0;
		repeat (3) @(posedge sys_clk);
		wb_rd(8'h00, 32'h18);
		check({31'h0, rx_buf}, 32'h1);
		// receive is on, so a resource fetch must be refused and flagged
		wb_wr(8'h00, 32'h100);
		wb_rd(8'h04, 32'h4);
		wb_rd(8'h00, 32'h18);
		wb_wr(8'h04, 32'h4);
		rx_busy <= 1'b1;
		wb_wr(8'h00, 32'h4);
		wb_rd(8'h00, 32'h1c);
		check({30'h0, rx_buf, tally_en}, 32'h3);
		rx_busy <= 1'b0;
		repeat (3) @(posedge sys_clk);
		wb_rd(8'h00, 32'h14);
		check({31'h0, rx_buf}, 32'h0);
		pulse(9'h100);
		wb_wr(8'h00, 32'h20);
		wb_rd(8'h00, 32'h24);
		wb_wr(8'h00, 32'h10);
		wb_rd(8'h00, 32'h14);
		c = cnt;
		check({31'h0, c < 32'd30}, 32'h1);
		repeat (4) @(posedge sys_clk);
		check(cnt, c);
		wb_wr(8'h00, 32'h30);
		wb_rd(8'h00, 32'h14);
		wb_wr(8'h00, 32'h20);
		n = 0;
		while (irq !== 1'b1 && n < 100)
		begin
			@(posedge sys_clk);
			n++;
		end
		check({31'h0, n < 100}, 32'h1);
		check(cnt, 32'h0);
		wb_rd(8'h00, 32'h14);
		// timer must stay frozen while soft reset holds the machines
		pulse(9'h100);
		wb_wr(8'h00, 32'h22);
		wb_rd(8'h00, 32'h26);
		wb_wr(8'h00, 32'h80);
		wb_rd(8'h00, 32'ha4);
		check({28'h0, hold, crc_en, tally_en, tx_run}, 32'h8);
		c = cnt;
		repeat (4) @(posedge sys_clk);
		check(cnt, c);
		wb_wr(8'h00, 32'h2);
		wb_rd(8'h00, 32'h26);
		// with the interrupt masked the timer still expires but stays silent
		irq_en <= 1'b0;
		n = 0;
		repeat (60)
		begin
			@(posedge sys_clk);
			if (irq !== 1'b0)
				n++;
		end
		check(n, 32'h0);
		check(cnt, 32'h0);
		wb_rd(8'h00, 32'h16);
		// a hardware reset in mid-run restores the power-up word
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		wb_rd(8'h00, 32'h94);
		check({29'h0, hold, crc_en, tally_en}, 32'h4);
		give_verdict();
	end
endmodule
`default_nettype wire
